// ==== hdl/host_port_cfg.svh ====
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// Command queue geometry.
`define HP_QUEUE_DEPTH      4'h8
`define HP_QPTR_W           3
`define HP_CMD_WORD_INDEX   6'h00
`define HP_CMD_MSB_BYTE     2'h3
`define HP_CMD_LSB_BYTE     2'h0

// Bit positions inside the synchronised pin bundle.
`define HP_PIN_W            13
`define HP_PIN_SEN          12
`define HP_PIN_SDA          11
`define HP_PIN_ALE          10
`define HP_PIN_WE           9
`define HP_PIN_CSN          8

// Filter and strap counts in link clock cycles; byte length in serial clock bits.
`define HP_FILTER_LEN       3
`define HP_STRAP_WAIT       2'h2
`define HP_BYTE_BITS        4'h8

`endif

// ==== hdl/host_port_pkg.sv ====
package host_port_pkg;

  typedef enum logic [2:0] {
    SER_IDLE      = 3'h0,
    SER_ADDR      = 3'h1,
    SER_ADDR_ACK  = 3'h3,
    SER_WRITE     = 3'h2,
    SER_WRITE_ACK = 3'h6,
    SER_READ      = 3'h7,
    SER_READ_ACK  = 3'h5,
    SER_IGNORE    = 3'h4
  } ser_state_t;

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic        serial_mode;
    logic        cur_wr;
    logic        cur_rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  dout;
    logic        dout_oe;
    logic [2:0]  scl_h;
    logic [2:0]  sda_h;
    logic        f_scl;
    logic        f_sda;
    logic        p_scl;
    logic        p_sda;
    ser_state_t  st;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  txreg;
    logic [7:0]  ptr;
    logic        rw;
    logic        first_wr;
    logic        sda_oe;
    logic        sda_out;
    logic [23:0] wbuf;
    logic [31:0] latch;
    logic        push_req;
    logic [31:0] push_word;
    logic        pack_s1;
    logic        pack_s2;
    logic        areq_s1;
    logic        areq_s2;
    logic        aseen;
    logic [31:0] mirror;
  } link_state_t;

  typedef struct packed {
    logic        preq_s1;
    logic        preq_s2;
    logic        preq_seen;
    logic        aack_s1;
    logic        aack_s2;
    logic        areq;
    logic [31:0] aword;
    logic [31:0] active;
    logic        busy;
    logic        start;
    logic [2:0]  head;
    logic [2:0]  tail;
    logic [3:0]  count;
    logic        drop;
    logic        full;
  } core_state_t;

endpackage : host_port_pkg

// ==== hdl/cmd_queue_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "host_port_cfg.svh"

module cmd_queue_mem (
  input  wire logic                     clk_i,
  input  wire logic                     we_i,
  input  wire logic [`HP_QPTR_W-1:0]    waddr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic [`HP_QPTR_W-1:0]    raddr_i,
  output logic      [31:0]              rdata_o
);

  logic [31:0] mem [0:(1<<`HP_QPTR_W)-1];

  // A write to the entry being read is forwarded so a fresh entry is seen at once.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : cmd_queue_mem
`default_nettype wire

// ==== hdl/host_bus_and_command_queue_port.sv ====
// How it works
// - Parallel write happens only in overlap of chip select, write strobe, latch inactive.
// - Chip select alone with strobes inactive is a read; data out within three clocks.
// - Serial device address comes from the seven upper address/data pins.
// - Serial clock and data are filtered over three system clocks.
// - Serial register pointer increments after every byte access.
// - Data changes while clock high are start or stop conditions.
// - Serial data is open drain only; serial clock is input only.
// - Lower bytes are buffered; the top byte commits the whole word.
// - Reading byte zero snapshots the register; upper bytes come from the snapshot.
// - All state except the queue storage clears at reset; enable bits are active high.
// - Queued commands execute one at a time, in order, after termination.
// - Next command starts within three clocks of termination.
// - Writing the word at offset zero appends a command to the queue.
// - Reading offset zero returns the command in execution.
// - Interface strap is sampled once after reset release.
`timescale 1ns/100ps
`default_nettype none
`include "host_port_cfg.svh"

module host_bus_and_command_queue_port (
  input  wire logic        core_clk_i,
  input  wire logic        link_clk_i,
  input  wire logic        rst_i,
  input  wire logic        serial_en_i,
  input  wire logic        cs_n_i,
  input  wire logic        ale_i,
  input  wire logic        write_strobe_serial_clock_pin_i,
  input  wire logic        sda_i,
  input  wire logic [7:0]  mux_addr_data_pins_i,
  output logic      [7:0]  mux_addr_data_pins_o,
  output logic             mux_addr_data_pins_oe_o,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             serial_mode_o,
  input  wire logic        cmd_done_i,
  output logic      [31:0] active_cmd_o,
  output logic             cmd_busy_o,
  output logic             cmd_start_o,
  output logic             queue_full_o,
  output logic             queue_drop_o
);

  host_port_pkg::link_state_t l;
  host_port_pkg::link_state_t next_l;
  host_port_pkg::core_state_t c;
  host_port_pkg::core_state_t next_c;
  logic [31:0]                q_rdata;
  logic                       q_we;

  // Byte view of the register space; only the command word is mapped.
  function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [31:0] live, input logic [31:0] snap);
    logic [7:0] r;
    r = 8'h00;
    if (a[7:2] == `HP_CMD_WORD_INDEX) begin
      case (a[1:0])
        2'h0:    r = live[7:0];
        2'h1:    r = snap[15:8];
        2'h2:    r = snap[23:16];
        default: r = snap[31:24];
      endcase
    end
    return r;
  endfunction : read_byte

  // ----------------------------------------------------------------
  // Link domain: pins, filters, parallel and serial decoding
  // ----------------------------------------------------------------
  always_comb begin
    logic       wr_go;
    logic [7:0] wr_a;
    logic [7:0] wr_d;
    logic       rd_go;
    logic [7:0] rd_a;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       par_wr;
    logic       par_rd;
    logic [7:0] rb;
    wr_go = 1'b0;
    rb    = read_byte(l.ptr, l.mirror, l.latch);
    wr_a  = 8'h00;
    wr_d  = 8'h00;
    rd_go = 1'b0;
    rd_a  = 8'h00;
    next_l = l;
    next_l.s1 = {serial_en_i, sda_i, ale_i, write_strobe_serial_clock_pin_i, cs_n_i, mux_addr_data_pins_i};
    next_l.s2 = l.s1;
    next_l.pack_s1 = c.preq_seen;
    next_l.pack_s2 = l.pack_s1;
    next_l.areq_s1 = c.areq;
    next_l.areq_s2 = l.areq_s1;
    // The strap is caught from the synchronised level once, after release.
    if (!l.strap_done) begin
      if (l.strap_cnt == `HP_STRAP_WAIT) begin
        next_l.strap_done  = 1'b1;
        next_l.serial_mode = l.s2[`HP_PIN_SEN];
      end else begin
        next_l.strap_cnt = l.strap_cnt + 2'h1;
      end
    end
    // Active command mirror arrives by a toggle handshake from the core.
    if (l.areq_s2 != l.aseen) begin
      next_l.aseen  = l.areq_s2;
      next_l.mirror = c.aword;
    end
    // Three equal samples are needed before a serial line level is believed.
    next_l.scl_h = {l.scl_h[1:0], l.s2[`HP_PIN_WE]};
    next_l.sda_h = {l.sda_h[1:0], l.s2[`HP_PIN_SDA]};
    if (l.scl_h == 3'h7) next_l.f_scl = 1'b1;
    if (l.scl_h == 3'h0) next_l.f_scl = 1'b0;
    if (l.sda_h == 3'h7) next_l.f_sda = 1'b1;
    if (l.sda_h == 3'h0) next_l.f_sda = 1'b0;
    next_l.p_scl = l.f_scl;
    next_l.p_sda = l.f_sda;
    scl_rise = l.f_scl && !l.p_scl;
    scl_fall = !l.f_scl && l.p_scl;
    start_c  = l.p_sda && !l.f_sda && l.f_scl && l.p_scl;
    stop_c   = !l.p_sda && l.f_sda && l.f_scl && l.p_scl;
    par_wr = l.strap_done && !l.serial_mode && !l.s2[`HP_PIN_CSN] && !l.s2[`HP_PIN_WE] && !l.s2[`HP_PIN_ALE];
    par_rd = l.strap_done && !l.serial_mode && !l.s2[`HP_PIN_CSN] && l.s2[`HP_PIN_WE] && !l.s2[`HP_PIN_ALE];
    next_l.cur_wr = par_wr;
    next_l.cur_rd = par_rd;
    // Parallel port.
    if (l.strap_done && !l.serial_mode) begin
      if (l.s2[`HP_PIN_ALE]) next_l.addr = l.s2[7:0];
      // Data is taken while the strobe is held, the access acts when it ends.
      if (par_wr) next_l.wdata = l.s2[7:0];
      if (l.cur_wr && !par_wr) begin
        wr_go = 1'b1;
        wr_a  = l.addr;
        wr_d  = l.wdata;
      end
      if (par_rd && !l.cur_rd) begin
        rd_go = 1'b1;
        rd_a  = l.addr;
        next_l.dout    = read_byte(l.addr, l.mirror, l.latch);
        next_l.dout_oe = 1'b1;
      end
      if (!par_rd) next_l.dout_oe = 1'b0;
    end
    // Serial port.
    if (l.strap_done && l.serial_mode) begin
      if (start_c) begin
        next_l.st       = host_port_pkg::SER_ADDR;
        next_l.bitcnt   = 4'h0;
        next_l.first_wr = 1'b1;
        next_l.sda_oe   = 1'b0;
      end else if (stop_c) begin
        next_l.st     = host_port_pkg::SER_IDLE;
        next_l.sda_oe = 1'b0;
      end else begin
        case (l.st)
          host_port_pkg::SER_ADDR, host_port_pkg::SER_WRITE: begin
            if (scl_rise) begin
              next_l.shreg  = {l.shreg[6:0], l.f_sda};
              next_l.bitcnt = l.bitcnt + 4'h1;
            end
            if (scl_fall && l.bitcnt == `HP_BYTE_BITS) begin
              next_l.sda_oe = 1'b1;
              if (l.st == host_port_pkg::SER_ADDR) begin
                if (l.shreg[7:1] == l.s2[7:1]) begin
                  next_l.rw = l.shreg[0];
                  next_l.st = host_port_pkg::SER_ADDR_ACK;
                end else begin
                  next_l.sda_oe = 1'b0;
                  next_l.st     = host_port_pkg::SER_IGNORE;
                end
              end else begin
                next_l.st = host_port_pkg::SER_WRITE_ACK;
                if (l.first_wr) begin
                  next_l.first_wr = 1'b0;
                  next_l.ptr      = l.shreg;
                end else begin
                  wr_go      = 1'b1;
                  wr_a       = l.ptr;
                  wr_d       = l.shreg;
                  next_l.ptr = l.ptr + 8'h01;
                end
              end
            end
          end
          host_port_pkg::SER_ADDR_ACK: begin
            if (scl_fall) begin
              next_l.bitcnt = 4'h0;
              if (l.rw) begin
                rd_go = 1'b1;
                rd_a  = l.ptr;
                next_l.txreg  = rb;
                next_l.sda_oe = !rb[7];
                next_l.st     = host_port_pkg::SER_READ;
              end else begin
                next_l.sda_oe = 1'b0;
                next_l.st     = host_port_pkg::SER_WRITE;
              end
            end
          end
          host_port_pkg::SER_WRITE_ACK: begin
            if (scl_fall) begin
              next_l.sda_oe = 1'b0;
              next_l.bitcnt = 4'h0;
              next_l.st     = host_port_pkg::SER_WRITE;
            end
          end
          host_port_pkg::SER_READ: begin
            if (scl_rise) next_l.bitcnt = l.bitcnt + 4'h1;
            if (scl_fall) begin
              if (l.bitcnt == `HP_BYTE_BITS) begin
                next_l.sda_oe = 1'b0;
                next_l.ptr    = l.ptr + 8'h01;
                next_l.st     = host_port_pkg::SER_READ_ACK;
              end else begin
                next_l.txreg  = {l.txreg[6:0], 1'b0};
                next_l.sda_oe = !l.txreg[6];
              end
            end
          end
          host_port_pkg::SER_READ_ACK: begin
            if (scl_rise && l.f_sda) next_l.st = host_port_pkg::SER_IGNORE;
            if (scl_fall) begin
              rd_go = 1'b1;
              rd_a  = l.ptr;
              next_l.bitcnt = 4'h0;
              next_l.txreg  = rb;
              next_l.sda_oe = !rb[7];
              next_l.st     = host_port_pkg::SER_READ;
            end
          end
          host_port_pkg::SER_IGNORE: next_l.sda_oe = 1'b0;
          default: begin
            next_l.sda_oe = 1'b0;
            next_l.st     = host_port_pkg::SER_IDLE;
          end
        endcase
      end
    end
    // Shared byte access effects.
    if (rd_go && rd_a[7:2] == `HP_CMD_WORD_INDEX && rd_a[1:0] == `HP_CMD_LSB_BYTE) begin
      next_l.latch = l.mirror;
    end
    if (wr_go && wr_a[7:2] == `HP_CMD_WORD_INDEX) begin
      case (wr_a[1:0])
        2'h0:    next_l.wbuf[7:0]   = wr_d;
        2'h1:    next_l.wbuf[15:8]  = wr_d;
        2'h2:    next_l.wbuf[23:16] = wr_d;
        default: begin
          // A commit while the previous word is still crossing is lost.
          if (l.push_req == l.pack_s2) begin
            next_l.push_word = {wr_d, l.wbuf};
            next_l.push_req  = !l.push_req;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign mux_addr_data_pins_o    = l.dout;
  assign mux_addr_data_pins_oe_o = l.dout_oe;
  assign sda_o                   = l.sda_out;
  assign sda_oe_o                = l.sda_oe;
  assign serial_mode_o           = l.serial_mode;

  // ----------------------------------------------------------------
  // Core domain: queue and sequential execution
  // ----------------------------------------------------------------
  always_comb begin
    logic push;
    logic pop;
    next_c = c;
    next_c.preq_s1 = l.push_req;
    next_c.preq_s2 = c.preq_s1;
    next_c.aack_s1 = l.aseen;
    next_c.aack_s2 = c.aack_s1;
    next_c.start   = 1'b0;
    next_c.drop    = 1'b0;
    push = c.preq_s2 != c.preq_seen;
    pop  = (!c.busy || cmd_done_i) && (c.count != 4'h0);
    if (push) next_c.preq_seen = c.preq_s2;
    q_we = push && !c.full;
    if (push && c.full) next_c.drop = 1'b1;
    if (q_we) next_c.tail = c.tail + 3'h1;
    if (pop) begin
      next_c.active = q_rdata;
      next_c.busy   = 1'b1;
      next_c.start  = 1'b1;
      next_c.head   = c.head + 3'h1;
    end else if (c.busy && cmd_done_i) begin
      next_c.busy   = 1'b0;
      next_c.active = 32'h0000_0000;
    end
    next_c.count = c.count + {3'h0, q_we} - {3'h0, pop};
    next_c.full  = next_c.count == `HP_QUEUE_DEPTH;
    // The word is held until the link side has answered the toggle.
    if (c.areq == c.aack_s2 && c.aword != c.active) begin
      next_c.aword = c.active;
      next_c.areq  = !c.areq;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  cmd_queue_mem u_queue (
    .clk_i   (core_clk_i),
    .we_i    (q_we),
    .waddr_i (c.tail),
    .wdata_i (c.preq_s2 != c.preq_seen ? l.push_word : 32'h0000_0000),
    .raddr_i (next_c.head),
    .rdata_o (q_rdata)
  );

  assign active_cmd_o = c.active;
  assign cmd_busy_o   = c.busy;
  assign cmd_start_o  = c.start;
  assign queue_full_o = c.full;
  assign queue_drop_o = c.drop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  write_overlap_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (!l.serial_mode && $changed(l.push_req)) |-> $past(l.cur_wr) && !$past(par_wr_now()))
    else $error("parallel commit outside a write overlap end");

  read_latency_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (l.strap_done && !l.serial_mode && $rose(l.cur_rd)) |-> l.dout_oe ##1 l.dout_oe || !l.cur_rd)
    else $error("read data not driven in time");

  filter_three_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $changed(l.f_scl) |-> $past(l.scl_h) == {3{l.f_scl}})
    else $error("serial clock filter changed without three equal samples");

  pointer_inc_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    ($past(l.st) == host_port_pkg::SER_READ && l.st == host_port_pkg::SER_READ_ACK)
      |-> l.ptr == $past(l.ptr) + 8'h01)
    else $error("serial pointer did not advance after a read byte");

  open_drain_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    l.sda_oe |-> !sda_o)
    else $error("serial data driven high");

  snapshot_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    ($rose(l.cur_rd) && l.addr == 8'h00 && !l.serial_mode) |-> l.latch == $past(l.mirror))
    else $error("byte zero read did not snapshot the register");

  strap_once_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $past(l.strap_done) |-> $stable(l.serial_mode))
    else $error("interface mode changed after strap capture");

  changeover_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c.busy && cmd_done_i && c.count != 4'h0) |=> c.start && c.busy && c.active == $past(q_rdata))
    else $error("next command not started after termination");

  one_at_time_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c.busy && !cmd_done_i) |=> !c.start && $stable(c.active))
    else $error("command replaced before termination");

  full_drop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    c.full |-> !q_we ##1 c.count == `HP_QUEUE_DEPTH || c.start)
    else $error("full queue accepted a command");

  append_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (q_we && !(c.busy ? cmd_done_i : 1'b1)) |=> c.count == $past(c.count) + 4'h1)
    else $error("queue write did not append an entry");

  function automatic logic par_wr_now();
    return l.strap_done && !l.serial_mode && !l.s2[`HP_PIN_CSN] && !l.s2[`HP_PIN_WE] && !l.s2[`HP_PIN_ALE];
  endfunction : par_wr_now

endmodule : host_bus_and_command_queue_port
`default_nettype wire

// ==== verification/host_mcu_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module host_mcu_model (
  input  wire logic       link_clk_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            cs_n_o,
  output logic            ale_o,
  output logic            we_n_o,
  output logic      [7:0] pins_o
);
  logic [7:0] drive;
  logic       host_en;

  // Released pins show the inverse of the last byte, so a stale value never passes for read data.
  assign pins_o = dev_oe_i ? dev_data_i : (host_en ? drive : ~drive);

  initial begin
    cs_n_o = 1'b1;
    ale_o = 1'b0;
    we_n_o = 1'b1;
    drive = 8'h00;
    host_en = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge link_clk_i);
    #1;
  endtask : hold

  task automatic put_addr(input logic [7:0] a);
    hold(1);
    host_en = 1'b1;
    drive = a;
    ale_o = 1'b1;
    hold(4);
    ale_o = 1'b0;
    hold(1);
  endtask : put_addr

  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    put_addr(a);
    drive = d;
    we_n_o = 1'b0;
    hold(1);
    cs_n_o = 1'b0;
    hold(4);
    cs_n_o = 1'b1;
    we_n_o = 1'b1;
    hold(12);
  endtask : write_byte

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic late);
    int n;
    put_addr(a);
    host_en = 1'b0;
    cs_n_o = 1'b0;
    n = 0;
    while (dev_oe_i !== 1'b1 && n < 3) begin
      hold(1);
      n++;
    end
    late = (dev_oe_i !== 1'b1);
    d = pins_o;
    cs_n_o = 1'b1;
    hold(6);
    host_en = 1'b1;
  endtask : read_byte

  // Start, one address byte, acknowledge bit, stop; the strap byte sits on the address pins.
  task automatic ser_addr(input logic [7:0] strap, input logic [7:0] b, output logic ack);
    drive = strap;
    we_n_o = 1'b1;
    sda_o = 1'b1;
    hold(8);
    sda_o = 1'b0;
    hold(8);
    for (int i = 7; i >= 0; i--) begin
      we_n_o = 1'b0;
      hold(4);
      sda_o = b[i];
      hold(4);
      we_n_o = 1'b1;
      hold(8);
    end
    we_n_o = 1'b0;
    hold(4);
    sda_o = 1'b1;
    hold(4);
    we_n_o = 1'b1;
    hold(4);
    ack = (sda_i === 1'b0);
    hold(4);
    we_n_o = 1'b0;
    hold(4);
    sda_o = 1'b0;
    hold(4);
    we_n_o = 1'b1;
    hold(8);
    sda_o = 1'b1;
    hold(8);
  endtask : ser_addr
endmodule : host_mcu_model

`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } read_row_t;

  localparam logic [31:0]     FIRST_CMD = 32'hA1B2C3D4;
  localparam logic [31:0]     NEXT_CMD  = 32'h55667788;
  localparam logic [31:0]     FILL_BASE = 32'h10000000;
  localparam read_row_t [4:0] ROWS      = {16'h0400, 16'h03A1, 16'h02B2, 16'h01C3, 16'h00D4};

  logic        core_clk_i;
  logic        link_clk_i;
  logic        rst_i;
  logic        cmd_done_i;
  logic        cs_n;
  logic        ale;
  logic        we_n;
  logic        sda_line;
  logic        host_sda;
  logic        serial_en;
  logic        ack;
  logic [7:0]  pins;
  logic [7:0]  dev_data;
  logic        dev_oe;
  logic        sda_oe;
  logic        serial_mode;
  logic [31:0] active_cmd_o;
  logic        cmd_busy_o;
  logic        cmd_start;
  logic        queue_full_o;
  logic        queue_drop;
  int          mismatches;
  int          checks_done;
  int          starts;
  int          drops;
  int          cycles;
  int          k;

  // ----------------------------------------------------------------
  // Clocks and the wiring of the two parties
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end

  // The serial line has a pull-up, so it is high unless the host or the device pulls it low.
  assign sda_line = host_sda & ~sda_oe;

  host_mcu_model host_mcu_model_inst (
    .link_clk_i (link_clk_i),
    .dev_data_i (dev_data),
    .dev_oe_i   (dev_oe),
    .sda_i      (sda_line),
    .sda_o      (host_sda),
    .cs_n_o     (cs_n),
    .ale_o      (ale),
    .we_n_o     (we_n),
    .pins_o     (pins)
  );

  host_bus_and_command_queue_port host_bus_and_command_queue_port_inst (
    .core_clk_i                      (core_clk_i),
    .link_clk_i                      (link_clk_i),
    .rst_i                           (rst_i),
    .serial_en_i                     (serial_en),
    .cs_n_i                          (cs_n),
    .ale_i                           (ale),
    .write_strobe_serial_clock_pin_i (we_n),
    .sda_i                           (sda_line),
    .mux_addr_data_pins_i            (pins),
    .mux_addr_data_pins_o            (dev_data),
    .mux_addr_data_pins_oe_o         (dev_oe),
    .sda_o                           (),
    .sda_oe_o                        (sda_oe),
    .serial_mode_o                   (serial_mode),
    .cmd_done_i                      (cmd_done_i),
    .active_cmd_o                    (active_cmd_o),
    .cmd_busy_o                      (cmd_busy_o),
    .cmd_start_o                     (cmd_start),
    .queue_full_o                    (queue_full_o),
    .queue_drop_o                    (queue_drop)
  );

  always @(posedge core_clk_i) begin
    cycles++;
    if (rst_i === 1'b0 && cmd_start === 1'b1) begin
      starts++;
    end
    if (rst_i === 1'b0 && queue_drop === 1'b1) begin
      drops++;
    end
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got 0x%h, expected 0x%h", $time, got, exp);
    end
  endtask : check

  task automatic core_wait(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : core_wait

  task automatic write_word(input logic [31:0] w);
    for (int b = 0; b < 4; b++) begin
      host_mcu_model_inst.write_byte(b[7:0], w[8*b +: 8]);
    end
    core_wait(20);
  endtask : write_word

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       late;
    host_mcu_model_inst.read_byte(a, d, late);
    check({31'h0, late}, 32'h0);
    check({24'h0, d}, {24'h0, exp});
  endtask : read_check

  task automatic pulse_done(input logic [31:0] exp);
    int n;
    core_wait(1);
    cmd_done_i = 1'b1;
    core_wait(1);
    cmd_done_i = 1'b0;
    n = 0;
    while (active_cmd_o !== exp && n < 2) begin
      core_wait(1);
      n++;
    end
    check(active_cmd_o, exp);
  endtask : pulse_done

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    serial_en = 1'b0;
    cmd_done_i = 1'b0;
    core_wait(6);
    rst_i = 1'b0;
    check(active_cmd_o, 32'h0);
    check({27'h0, cmd_busy_o, queue_full_o, serial_mode, dev_oe, sda_oe}, 32'h0);
    core_wait(20);
    check({31'h0, serial_mode}, 32'h0);
    for (int b = 0; b < 3; b++) begin
      host_mcu_model_inst.write_byte(b[7:0], FIRST_CMD[8*b +: 8]);
    end
    core_wait(20);
    check({31'h0, cmd_busy_o}, 32'h0);
    host_mcu_model_inst.write_byte(8'h03, FIRST_CMD[31:24]);
    core_wait(20);
    check(active_cmd_o, FIRST_CMD);
    check({31'h0, cmd_busy_o}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      read_check(ROWS[i].addr, ROWS[i].data);
    end
    // The snapshot taken at byte 0 must survive a change of the running command.
    write_word(NEXT_CMD);
    read_check(8'h00, FIRST_CMD[7:0]);
    pulse_done(NEXT_CMD);
    core_wait(30);
    for (int b = 1; b < 4; b++) begin
      read_check(b[7:0], FIRST_CMD[8*b +: 8]);
    end
    pulse_done(32'h0);
    check({31'h0, cmd_busy_o}, 32'h0);
    k = 0;
    while (queue_full_o !== 1'b1 && k < 12) begin
      write_word(FILL_BASE + k);
      k++;
    end
    check({31'h0, queue_full_o}, 32'h1);
    write_word(32'hFFFFEEEE);
    check(drops, 32'h1);
    check(active_cmd_o, FILL_BASE);
    for (int j = 0; j < k; j++) begin
      pulse_done((j + 1 < k) ? FILL_BASE + j + 1 : 32'h0);
    end
    check(starts, 2 + k);
    write_word(FIRST_CMD);
    rst_i = 1'b1;
    serial_en = 1'b1;
    core_wait(2);
    check(active_cmd_o, 32'h0);
    check({31'h0, cmd_busy_o}, 32'h0);
    rst_i = 1'b0;
    core_wait(10);
    check({31'h0, serial_mode}, 32'h1);
    host_mcu_model_inst.ser_addr(8'h5A, 8'h5A, ack);
    check({31'h0, ack}, 32'h1);
    host_mcu_model_inst.ser_addr(8'h5A, 8'h24, ack);
    check({31'h0, ack}, 32'h0);
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
